// >>> design/mcd_pkg.sv
// Package for the move-class instruction decoder: opcodes, register map, reset values
package mcd_pkg;
	localparam int INSN_W = 12;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int FILE_DEPTH = 32;
	// Opcode patterns
	localparam logic [5:0] MOVE_FILE_HI = 6'h08;
	localparam logic [3:0] LOAD_LIT_HI = 4'hC;
	localparam logic [6:0] STORE_W_HI = 7'h01;
	localparam logic [11:0] NOP_WORD = 12'h000;
	localparam logic [11:0] OPTION_WORD = 12'h002;
	// Wishbone register map (byte addresses)
	localparam logic [7:0] ADR_INSN = 8'h00;
	localparam logic [7:0] ADR_WORK = 8'h04;
	localparam logic [7:0] ADR_OPTION = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_FILE_BASE = 8'h80;
	// Reset values
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam logic [7:0] FILE_RST = 8'h00;
	// Status bit positions
	localparam int ST_ZERO = 0;
	localparam int ST_ILLEGAL = 1;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_MOVE_FILE = 3'b001,
		OP_LOAD_LIT = 3'b010,
		OP_STORE_W = 3'b011,
		OP_NOP = 3'b100,
		OP_OPTION = 3'b101,
		OP_OTHER = 3'b110
	} mcd_op_t;
	typedef struct packed {
		mcd_op_t op;
		logic dest_file;
		logic [4:0] faddr;
		logic [7:0] lit;
	} mcd_dec_t;
	typedef struct packed {
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} mcd_wb_req_t;
endpackage

// >>> design/mcd_core.sv
// Move-class instruction decode and execute core with a Wishbone register slave
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/100ps

// Summary of operation
// - Word 001000dfffff moves file f to the destination picked by d, in one cycle.
// - With d clear the file value is copied to the working register; the file is unchanged.
// - With d set the file value is written back into that same file register.
// - A file move sets zero from the moved value for either d; a write-back is a zero test.
// - Word 1100kkkkkkkk loads k into the working register in one cycle, leaving flags alone.
// - Word 0000001fffff copies the working register into file f in one cycle, flags unchanged.
module mcd_core
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Instruction stream from program memory
	input wire logic [11:0] insn_i,
	input wire logic insn_valid_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core state
	output logic [7:0] work_o,
	output logic [7:0] option_o,
	output logic zero_o,
	output logic done_o
);
	logic [7:0] file_ff [mcd_pkg::FILE_DEPTH];
	logic [7:0] work_ff;
	logic [7:0] option_ff;
	logic zero_ff;
	logic illegal_ff;
	logic done_ff;
	logic [11:0] last_insn_ff;
	logic [31:0] wb_dat_ff;
	logic wb_ack_ff;
	mcd_pkg::mcd_dec_t dec;
	mcd_pkg::mcd_wb_req_t req;
	logic exec;
	logic [7:0] file_rd;
	logic wb_go;
	logic wb_wr;
	logic wb_file_hit;
	logic [4:0] wb_faddr;

	assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
		cyc: wb_cyc_i, stb: wb_stb_i};
	assign wb_go = req.cyc && req.stb && !wb_ack_ff;
	assign wb_wr = wb_go && req.we && req.sel[0];
	assign wb_file_hit = req.adr[7:0] >= mcd_pkg::ADR_FILE_BASE;
	assign wb_faddr = req.adr[6:2];
	// Instruction beats the bus in the same cycle; bus writes only touch what the core left alone
	assign exec = insn_valid_i;

	always_comb
	begin
		dec = '{op: mcd_pkg::OP_OTHER, dest_file: insn_i[5], faddr: insn_i[4:0],
			lit: insn_i[7:0]};
		if (insn_i[11:6] == mcd_pkg::MOVE_FILE_HI)
			dec.op = mcd_pkg::OP_MOVE_FILE;
		else if (insn_i[11:8] == mcd_pkg::LOAD_LIT_HI)
			dec.op = mcd_pkg::OP_LOAD_LIT;
		else if (insn_i[11:5] == mcd_pkg::STORE_W_HI)
			dec.op = mcd_pkg::OP_STORE_W;
		else if (insn_i == mcd_pkg::NOP_WORD)
			dec.op = mcd_pkg::OP_NOP;
		else if (insn_i == mcd_pkg::OPTION_WORD)
			dec.op = mcd_pkg::OP_OPTION;
		if (!exec)
			dec.op = mcd_pkg::OP_NONE;
	end

	assign file_rd = file_ff[dec.faddr];

	// File registers, one flop per entry; an instruction wins over a bus write to the same entry
	for (genvar g = 0; g < mcd_pkg::FILE_DEPTH; g++)
	begin : gen_file
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				file_ff[g] <= mcd_pkg::FILE_RST;
			else if (dec.op == mcd_pkg::OP_STORE_W && dec.faddr == 5'(g))
				file_ff[g] <= work_ff;
			else if (dec.op == mcd_pkg::OP_MOVE_FILE && dec.dest_file && dec.faddr == 5'(g))
				file_ff[g] <= file_rd;
			else if (wb_wr && wb_file_hit && wb_faddr == 5'(g))
				file_ff[g] <= req.dat[7:0];
		end
	end

	// Working register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			work_ff <= mcd_pkg::WORK_RST;
		else if (dec.op == mcd_pkg::OP_MOVE_FILE && !dec.dest_file)
			work_ff <= file_rd;
		else if (dec.op == mcd_pkg::OP_LOAD_LIT)
			work_ff <= dec.lit;
		else if (dec.op == mcd_pkg::OP_NONE && wb_wr && req.adr[7:0] == mcd_pkg::ADR_WORK)
			work_ff <= req.dat[7:0];
	end

	// Option register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			option_ff <= mcd_pkg::OPTION_RST;
		else if (dec.op == mcd_pkg::OP_OPTION)
			option_ff <= work_ff;
	end

	// Status flags; a file move sets zero, else a bus write to the status register does
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			zero_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end
		else
		begin
			if (dec.op == mcd_pkg::OP_MOVE_FILE)
				zero_ff <= (file_rd == 8'h00);
			else if (wb_wr && req.adr[7:0] == mcd_pkg::ADR_STATUS)
				zero_ff <= req.dat[mcd_pkg::ST_ZERO];
			// Sticky: a new foreign word wins over a clear in the same cycle
			if (dec.op == mcd_pkg::OP_OTHER)
				illegal_ff <= 1'b1;
			else if (wb_wr && req.adr[7:0] == mcd_pkg::ADR_STATUS && req.dat[mcd_pkg::ST_ILLEGAL])
				illegal_ff <= 1'b0;
		end
	end

	// Completion pulse and last word
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			done_ff <= 1'b0;
			last_insn_ff <= 12'h000;
		end
		else
		begin
			done_ff <= exec;
			if (exec)
				last_insn_ff <= insn_i;
		end
	end

	// Wishbone: ack one cycle after the strobe, dropped the next cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_ff <= wb_go;
			wb_dat_ff <= 32'h0000_0000;
			if (wb_go && !req.we)
			begin
				if (wb_file_hit)
					wb_dat_ff <= {24'h00_0000, file_ff[wb_faddr]};
				else
				begin
					case (req.adr[7:0])
						mcd_pkg::ADR_INSN: wb_dat_ff <= {20'h0_0000, last_insn_ff};
						mcd_pkg::ADR_WORK: wb_dat_ff <= {24'h00_0000, work_ff};
						mcd_pkg::ADR_OPTION: wb_dat_ff <= {24'h00_0000, option_ff};
						mcd_pkg::ADR_STATUS: wb_dat_ff <= {30'h0000_0000, illegal_ff, zero_ff};
						default: wb_dat_ff <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	assign wb_dat_o = wb_dat_ff;
	assign wb_ack_o = wb_ack_ff;
	assign work_o = work_ff;
	assign option_o = option_ff;
	assign zero_o = zero_ff;
	assign done_o = done_ff;

	// Checks
	load_lit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_LOAD_LIT |=> work_ff == $past(insn_i[7:0]) && $stable(zero_ff))
		else $error("literal load wrong");
	move_to_work_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE && !dec.dest_file |=> work_ff == $past(file_rd))
		else $error("file move to working register wrong");
	move_keep_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE && dec.dest_file |=> $stable(work_ff))
		else $error("file move back touched working register");
	move_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE |=> zero_ff == ($past(file_rd) == 8'h00))
		else $error("zero flag wrong after file move");
	move_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && insn_i[11:6] == 6'h08 |-> dec.op == mcd_pkg::OP_MOVE_FILE)
		else $error("file move not decoded");
	store_w_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_STORE_W |=> $stable(zero_ff) && $stable(work_ff))
		else $error("store of working register disturbed state");
	nop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_NOP |=> $stable(work_ff) && $stable(zero_ff) && $stable(option_ff))
		else $error("no-operation changed state");
	option_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_OPTION |=> option_ff == $past(work_ff) && done_ff)
		else $error("option load wrong");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_ff |=> !wb_ack_ff)
		else $error("ack held two cycles");

	// Decode checks
	lit_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && insn_i[11:8] == 4'hC |-> dec.op == mcd_pkg::OP_LOAD_LIT)
		else $error("literal load not decoded");
	store_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && insn_i[11:5] == 7'h01 |-> dec.op == mcd_pkg::OP_STORE_W)
		else $error("store of working register not decoded");
	nop_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && insn_i == 12'h000 |-> dec.op == mcd_pkg::OP_NOP)
		else $error("no-operation not decoded");
	option_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && insn_i == 12'h002 |-> dec.op == mcd_pkg::OP_OPTION)
		else $error("option load not decoded");
	illegal_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_OTHER |=> illegal_ff)
		else $error("foreign word not flagged");
	valid_no_illegal_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op != mcd_pkg::OP_OTHER && !illegal_ff |=> !illegal_ff)
		else $error("known word flagged as foreign");
	illegal_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		illegal_ff && !wb_wr |=> illegal_ff)
		else $error("foreign word flag lost");
	other_keep_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_OTHER && !wb_wr |=> $stable(work_ff) && $stable(zero_ff)
			&& $stable(option_ff))
		else $error("foreign word changed state");

	// Datapath checks
	move_back_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE && dec.dest_file
			|=> file_ff[$past(dec.faddr)] == $past(file_rd))
		else $error("file move back wrote wrong value");
	move_keep_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE && !dec.dest_file && !wb_wr
			|=> file_ff[$past(dec.faddr)] == $past(file_rd))
		else $error("file move to working register changed the file");
	store_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_STORE_W |=> file_ff[$past(dec.faddr)] == $past(work_ff))
		else $error("store of working register wrote wrong value");
	exec_keep_work_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dec.op != mcd_pkg::OP_MOVE_FILE && dec.op != mcd_pkg::OP_LOAD_LIT |=> $stable(work_ff))
		else $error("working register changed by a word that keeps it");
	option_keep_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_OPTION && !wb_wr |=> $stable(zero_ff) && $stable(work_ff))
		else $error("option load disturbed state");
	option_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op != mcd_pkg::OP_OPTION |=> $stable(option_ff))
		else $error("option register changed without option load");
	flags_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op != mcd_pkg::OP_MOVE_FILE && !wb_wr |=> $stable(zero_ff))
		else $error("zero flag changed without file move");
	move_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_MOVE_FILE |=> done_ff)
		else $error("file move not done in one cycle");
	lit_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_LOAD_LIT |=> done_ff)
		else $error("literal load not done in one cycle");
	store_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dec.op == mcd_pkg::OP_STORE_W |=> done_ff)
		else $error("store not done in one cycle");
	idle_no_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!exec |=> !done_ff)
		else $error("done without a word");
	last_insn_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec |=> last_insn_ff == $past(insn_i))
		else $error("last word not kept");

	// Bus checks
	wb_ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_go |=> wb_ack_ff)
		else $error("ack not one cycle after request");
	wb_idle_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(req.cyc && req.stb) |=> !wb_ack_ff)
		else $error("ack without request");
	wb_write_work_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_wr && req.adr[7:0] == mcd_pkg::ADR_WORK && dec.op == mcd_pkg::OP_NONE
			|=> work_ff == $past(req.dat[7:0]))
		else $error("bus write to working register lost");
	wb_read_work_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_go && !req.we && req.adr[7:0] == mcd_pkg::ADR_WORK
			|=> wb_dat_ff == {24'h00_0000, $past(work_ff)})
		else $error("bus read of working register wrong");
	wb_read_file_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_go && !req.we && wb_file_hit |=> wb_dat_ff == {24'h00_0000, $past(file_ff[wb_faddr])})
		else $error("bus read of file register wrong");
	wb_status_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_wr && req.adr[7:0] == mcd_pkg::ADR_STATUS && dec.op != mcd_pkg::OP_MOVE_FILE
			|=> zero_ff == $past(req.dat[mcd_pkg::ST_ZERO]))
		else $error("bus write of zero flag lost");
	wb_write_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_go && req.we |=> wb_dat_ff == 32'h0000_0000)
		else $error("read data driven on a write");
endmodule // mcd_core

// >>> tb/mcd_pmem.sv
// Program memory model that hands the core one instruction word at a time
`timescale 1ns/100ps
module mcd_pmem
(
	// Clock
	input wire logic clk_i,
	// Instruction stream
	output logic [11:0] insn_o,
	output logic insn_valid_o
);
	initial
	begin
		insn_o = 12'hA5A;
		insn_valid_o = 1'b0;
	end
	// A released word shows its inverse, so a stale word never passes for a fresh one
	task automatic fetch(input logic [11:0] w);
		@(posedge clk_i);
		insn_o <= w;
		insn_valid_o <= 1'b1;
		@(posedge clk_i);
		insn_o <= ~w;
		insn_valid_o <= 1'b0;
	endtask
endmodule // mcd_pmem

// >>> tb/testbench.sv
// Self-checking bench for the move-class decoder
`timescale 1ns/100ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] insn;
	logic insn_valid;
	mcd_pkg::mcd_wb_req_t wb = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] work_o;
	logic [7:0] option_o;
	logic zero_o;
	logic done_o;
	logic [31:0] rd;
	int failures = 0;
	int compares = 0;
	always #2 clk_i = ~clk_i;
	mcd_pmem pmem (.clk_i(clk_i), .insn_o(insn), .insn_valid_o(insn_valid));
	mcd_core dut (.clk_i(clk_i), .rst_i(rst_i), .insn_i(insn), .insn_valid_i(insn_valid),
		.wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_adr_i(wb.adr),
		.wb_dat_i(wb.dat), .wb_sel_i(wb.sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.work_o(work_o), .option_o(option_o), .zero_o(zero_o), .done_o(done_o));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Done is looked at just after the edge that follows the taken word
	task automatic exec(input logic [11:0] w);
		pmem.fetch(w);
		#1;
		check(done_o, 1'b1);
	endtask
	task automatic wbx(input logic we, input logic [7:0] adr, input logic [7:0] d);
		@(posedge clk_i);
		wb <= '{adr: {24'h0, adr}, dat: {24'h0, d}, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
			if (i == 19)
			begin
				failures++;
				report_and_stop();
			end
		end
		rd = wb_dat_o;
		wb <= '0;
		@(posedge clk_i);
	endtask
	task automatic t_load;
		check(zero_o, 1'b0);
		exec(12'hC5A);
		check(work_o, 8'h5A);
		exec(12'hC00);
		check(work_o, 8'h00);
		check(zero_o, 1'b0);
		$display("load literal done");
	endtask
	task automatic t_store;
		exec(12'hCA5);
		exec(12'h03F);
		wbx(1'b0, 8'hFC, 8'h00);
		check(rd, 32'h0000_00A5);
		wbx(1'b0, 8'hF8, 8'h00);
		check(rd, 32'h0000_0000);
		check(zero_o, 1'b0);
		$display("store working done");
	endtask
	task automatic t_move;
		exec(12'hC11);
		exec(12'h21F);
		check(work_o, 8'hA5);
		check(zero_o, 1'b0);
		wbx(1'b0, 8'hFC, 8'h00);
		check(rd, 32'h0000_00A5);
		exec(12'h220);
		check(zero_o, 1'b1);
		check(work_o, 8'hA5);
		wbx(1'b1, 8'h88, 8'h3C);
		exec(12'h222);
		check(zero_o, 1'b0);
		wbx(1'b0, 8'h88, 8'h00);
		check(rd, 32'h0000_003C);
		// Near miss on the top six bits must not move anything
		pmem.fetch(12'h240);
		#1;
		check(work_o, 8'hA5);
		wbx(1'b0, 8'h0C, 8'h00);
		check(rd[1], 1'b1);
		$display("move file done");
	endtask
	task automatic t_misc;
		exec(12'h220);
		exec(12'hC37);
		check(zero_o, 1'b1);
		exec(12'h002);
		check(option_o, 8'h37);
		check(zero_o, 1'b1);
		exec(12'h000);
		check(work_o, 8'h37);
		check(option_o, 8'h37);
		wbx(1'b0, 8'h0C, 8'h00);
		check(rd, 32'h0000_0003);
		wbx(1'b0, 8'h08, 8'h00);
		check(rd, 32'h0000_0037);
		wbx(1'b1, 8'h04, 8'h5C);
		exec(12'h025);
		wbx(1'b0, 8'h94, 8'h00);
		check(rd, 32'h0000_005C);
		wbx(1'b1, 8'h0C, 8'h01);
		exec(12'h225);
		check(zero_o, 1'b0);
		check(work_o, 8'h5C);
		$display("option and nop done");
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check(option_o, 8'hFF);
		t_load();
		t_store();
		t_move();
		t_misc();
		report_and_stop();
	end
endmodule // testbench
